// ==== hdl/phy_autoneg_register_bank.sv ====
`timescale 1ns/100ps
`include "phy_an_cfg.svh"
module phy_autoneg_register_bank
  import phy_an_pkg::*;
#(
  parameter int          ADDR_W = 12,       // apb address width
  parameter logic [15:0] ID_LOW = 16'h5a5a  // arbitrary identifier value
) (
  input  wire logic              clk,      // core clock, 100 MHz
  input  wire logic              rst_n,    // synchronous reset, active low
  input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb enable
  input  wire logic              pwrite,   // apb direction
  input  wire logic [31:0]       pwdata,   // apb write data
  output logic      [31:0]       prdata,   // apb read data
  output logic                   pready,   // apb ready
  output logic                   pslverr,  // apb error, unmapped address
  input  wire an_event_t         an_evt,   // arbitration events
  output logic      [15:0]       adv_word, // advertised base page
  output logic      [15:0]       np_word,  // next page to transmit
  output logic                   irq       // level interrupt
);

  localparam logic [ADDR_W-1:0] A_ID   = ADDR_W'(`IDX_ID_LOW * 4);
  localparam logic [ADDR_W-1:0] A_ADV  = ADDR_W'(`IDX_ADV * 4);
  localparam logic [ADDR_W-1:0] A_LP   = ADDR_W'(`IDX_PARTNER * 4);
  localparam logic [ADDR_W-1:0] A_EXP  = ADDR_W'(`IDX_EXP * 4);
  localparam logic [ADDR_W-1:0] A_NP   = ADDR_W'(`IDX_NP * 4);
  localparam logic [ADDR_W-1:0] A_ISTA = ADDR_W'(`IDX_IRQ_STAT * 4);
  localparam logic [ADDR_W-1:0] A_IMSK = ADDR_W'(`IDX_IRQ_MASK * 4);

  reg_sel_t            sel;
  logic                setup_ph;
  logic                access_ph;
  logic                wr_acc;
  logic                rd_acc;
  logic [15:0]         adv_r;
  logic [15:0]         np_r;
  logic [15:0]         partner_r;
  logic                toggle_r;
  logic                lpan_r;
  logic [1:0]          exp_set;
  logic [1:0]          exp_clr;
  logic [1:0]          exp_q;
  logic [`IRQ_W-1:0]   ist_set;
  logic [`IRQ_W-1:0]   ist_clr;
  logic [`IRQ_W-1:0]   ist_q;
  logic [`IRQ_W-1:0]   imask_r;
  logic [15:0]         exp_val;
  logic [31:0]         rd_nxt;
  logic [31:0]         prdata_r;
  logic                pslverr_r;

  // address decode into a one-hot select
  always_comb begin
    case (paddr)
      A_ID:    sel = SEL_ID_LOW;
      A_ADV:   sel = SEL_ADV;
      A_LP:    sel = SEL_PARTNER;
      A_EXP:   sel = SEL_EXP;
      A_NP:    sel = SEL_NP;
      A_ISTA:  sel = SEL_IRQ_STAT;
      A_IMSK:  sel = SEL_IRQ_MASK;
      default: sel = SEL_NONE;
    endcase
  end

  // apb phases; every access completes without wait states
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite;
  assign rd_acc    = access_ph & ~pwrite;
  assign pready    = 1'b1;

  // advertisement: writable fields only, t4 and reserved stay zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adv_r <= `ADV_RST;                               // [R2] [R3] [R4] [R6]
    end else if (wr_acc && sel == SEL_ADV) begin
      adv_r <= pwdata[15:0] & `ADV_WMASK;              // [R2] [R3] [R4] [R5] [R6]
    end
  end

  // local next page: toggle is kept apart and never written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      np_r <= `NP_RST;                                 // [R14] [R15] [R16]
    end else if (wr_acc && sel == SEL_NP) begin
      np_r <= pwdata[15:0] & `NP_WMASK;                // [R14] [R15] [R16]
    end
  end

  // toggle of the previously transmitted code word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;                                // [R17]
    end else begin
      toggle_r <= an_evt.tx_toggle;                    // [R17]
    end
  end

  // partner base page capture, acknowledge forced once received
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      partner_r <= 16'h0000;
    end else if (an_evt.page_rx && an_evt.page_is_base) begin
      partner_r             <= an_evt.page_word;       // [R8]
      partner_r[`LP_ACK_BIT] <= 1'b1;                  // [R7]
    end
  end

  // partner auto-negotiation ability, live level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lpan_r <= 1'b0;
    end else begin
      lpan_r <= an_evt.partner_an_able;                // [R13]
    end
  end

  // latched expansion bits: bit 1 page received, bit 0 fault
  assign exp_set = {an_evt.page_rx, an_evt.par_fault};          // [R9] [R12]
  assign exp_clr = {2{rd_acc && sel == SEL_EXP}};               // [R18]

  sticky_bits #(
    .W (2)
  ) u_exp_latch (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (exp_set),
    .clr   (exp_clr),
    .q     (exp_q)
  );

  // expansion value as software sees it
  always_comb begin
    exp_val                = 16'h0000;
    exp_val[`EXP_PDF_BIT]  = exp_q[0];                 // [R9]
    exp_val[`EXP_LPNP_BIT] = partner_r[`LP_NP_BIT];    // [R10]
    exp_val[`EXP_NPA_BIT]  = 1'b1;                     // [R11]
    exp_val[`EXP_PR_BIT]   = exp_q[1];                 // [R12]
    exp_val[`EXP_LPAN_BIT] = lpan_r;                   // [R13]
  end

  // interrupt status: sticky, write one to clear
  always_comb begin
    ist_set                 = '0;
    ist_set[`IRQ_PAGE_BIT]  = an_evt.page_rx;
    ist_set[`IRQ_FAULT_BIT] = an_evt.par_fault;
    ist_set[`IRQ_BASE_BIT]  = an_evt.page_rx & an_evt.page_is_base;
  end
  assign ist_clr = (wr_acc && sel == SEL_IRQ_STAT) ? pwdata[`IRQ_W-1:0] : '0;

  sticky_bits #(
    .W (`IRQ_W)
  ) u_irq_status (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ist_set),
    .clr   (ist_clr),
    .q     (ist_q)
  );

  // interrupt mask
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      imask_r <= '0;
    end else if (wr_acc && sel == SEL_IRQ_MASK) begin
      imask_r <= pwdata[`IRQ_W-1:0];
    end
  end

  assign irq = |(ist_q & imask_r);

  // read mux, sampled in the setup phase
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (sel)
      SEL_ID_LOW:   rd_nxt[15:0] = ID_LOW;             // [R1]
      SEL_ADV:      rd_nxt[15:0] = adv_r;
      SEL_PARTNER:  rd_nxt[15:0] = partner_r;
      SEL_EXP:      rd_nxt[15:0] = exp_val;
      SEL_NP:       rd_nxt[15:0] = np_word;
      SEL_IRQ_STAT: rd_nxt[`IRQ_W-1:0] = ist_q;
      SEL_IRQ_MASK: rd_nxt[`IRQ_W-1:0] = imask_r;
      default:      rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data and error flop, valid through the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= (sel == SEL_NONE);
    end
  end

  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r & access_ph;
  assign adv_word = adv_r;
  assign np_word  = {np_r[15:12], toggle_r, np_r[10:0]};  // [R17]

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_id_fixed;
    setup_ph && !pwrite && sel == SEL_ID_LOW |=> prdata[15:0] == ID_LOW;
  endproperty
  a_id_fixed: assert property (p_id_fixed)  // [R1]
    else $error("identifier low word wrong");

  property p_adv_np_wr;
    wr_acc && sel == SEL_ADV |=> adv_word[`ADV_NP_BIT] == $past(pwdata[15]);
  endproperty
  a_adv_np_wr: assert property (p_adv_np_wr)  // [R2]
    else $error("next page advertisement not written");

  property p_adv_rf_wr;
    wr_acc && sel == SEL_ADV |=> adv_word[`ADV_RF_BIT] == $past(pwdata[13]);
  endproperty
  a_adv_rf_wr: assert property (p_adv_rf_wr)  // [R3]
    else $error("remote fault advertisement not written");

  property p_pause_rst;
    !$past(rst_n) |-> adv_word[`ADV_PAUSE_HI:`ADV_PAUSE_LO] == 2'b01
                      && adv_word[`ADV_NP_BIT] == 1'b0;
  endproperty
  a_pause_rst: assert property (p_pause_rst)  // [R4]
    else $error("pause field reset value wrong");

  property p_t4_zero;
    adv_word[`ADV_T4_BIT] == 1'b0 && adv_word[14] == 1'b0 && adv_word[12] == 1'b0;
  endproperty
  a_t4_zero: assert property (p_t4_zero)  // [R5]
    else $error("read-only advertisement bit set");

  property p_tech_wr;
    wr_acc && sel == SEL_ADV |=>
      adv_word[`ADV_TECH_HI:`ADV_TECH_LO] == $past(pwdata[8:5]);
  endproperty
  a_tech_wr: assert property (p_tech_wr)  // [R6]
    else $error("technology flags not written");

  property p_ack_seen;
    an_evt.page_rx && an_evt.page_is_base |=> partner_r[`LP_ACK_BIT] ##1
      partner_r[`LP_ACK_BIT];
  endproperty
  a_ack_seen: assert property (p_ack_seen)  // [R7]
    else $error("partner acknowledge not set");

  property p_lp_rf;
    an_evt.page_rx && an_evt.page_is_base |=>
      partner_r[`LP_RF_BIT] == $past(an_evt.page_word[13]);
  endproperty
  a_lp_rf: assert property (p_lp_rf)  // [R8]
    else $error("partner remote fault not captured");

  property p_fault_latch;
    an_evt.par_fault |=> exp_val[`EXP_PDF_BIT];
  endproperty
  a_fault_latch: assert property (p_fault_latch)  // [R9]
    else $error("parallel fault not latched");

  property p_lpnp;
    exp_val[`EXP_LPNP_BIT] == partner_r[`LP_NP_BIT];
  endproperty
  a_lpnp: assert property (p_lpnp)  // [R10]
    else $error("partner next page ability mismatch");

  property p_npa_one;
    setup_ph && !pwrite && sel == SEL_EXP |=> prdata[`EXP_NPA_BIT];
  endproperty
  a_npa_one: assert property (p_npa_one)  // [R11]
    else $error("next page able not one");

  property p_page_latch;
    an_evt.page_rx |=> exp_val[`EXP_PR_BIT];
  endproperty
  a_page_latch: assert property (p_page_latch)  // [R12]
    else $error("page received not latched");

  property p_lpan;
    ##1 exp_val[`EXP_LPAN_BIT] == $past(an_evt.partner_an_able);
  endproperty
  a_lpan: assert property (p_lpan)  // [R13]
    else $error("partner able level stale");

  property p_np_more;
    wr_acc && sel == SEL_NP |=> np_word[`NP_MORE_BIT] == $past(pwdata[15]);
  endproperty
  a_np_more: assert property (p_np_more)  // [R14]
    else $error("next page follows bit not written");

  property p_np_msg;
    wr_acc && sel == SEL_NP |=> np_word[`NP_MSG_BIT] == $past(pwdata[13]);
  endproperty
  a_np_msg: assert property (p_np_msg)  // [R15]
    else $error("message page bit not written");

  property p_np_ack2;
    wr_acc && sel == SEL_NP |=> np_word[`NP_ACK2_BIT] == $past(pwdata[12]);
  endproperty
  a_np_ack2: assert property (p_np_ack2)  // [R16]
    else $error("comply bit not written");

  property p_toggle;
    ##1 np_word[`NP_TOG_BIT] == $past(an_evt.tx_toggle);
  endproperty
  a_toggle: assert property (p_toggle)  // [R17]
    else $error("toggle bit does not follow");

  property p_hold_until_read;
    exp_q[1] && !(rd_acc && sel == SEL_EXP) |=> exp_q[1];
  endproperty
  a_hold_until_read: assert property (p_hold_until_read)  // [R18]
    else $error("latched bit dropped before read");

  property p_exp_clear;
    rd_acc && sel == SEL_EXP && !an_evt.page_rx && !an_evt.par_fault |=> exp_q == 2'b00;
  endproperty
  a_exp_clear: assert property (p_exp_clear)  // [R18]
    else $error("latched bit not released by read");

  property p_partner_ro;
    wr_acc && sel == SEL_PARTNER && !an_evt.page_rx |=> $stable(partner_r);
  endproperty
  a_partner_ro: assert property (p_partner_ro)  // [R7]
    else $error("partner ability changed by a write");

  property p_tech_rst;
    !$past(rst_n) |-> adv_word[`ADV_TECH_HI:`ADV_TECH_LO] == 4'hf
                      && adv_word[`ADV_RF_BIT] == 1'b0;
  endproperty
  a_tech_rst: assert property (p_tech_rst)  // [R6]
    else $error("technology flags reset value wrong");

  property p_np_rst;
    !$past(rst_n) |-> np_word[`NP_MSG_BIT] == 1'b1 && np_word[`NP_MORE_BIT] == 1'b0
                      && np_word[`NP_ACK2_BIT] == 1'b0 && np_word[`NP_TOG_BIT] == 1'b0;
  endproperty
  a_np_rst: assert property (p_np_rst)  // [R15]
    else $error("next page reset value wrong");

  c_page_read: cover property (an_evt.page_rx ##[1:20] (rd_acc && sel == SEL_EXP));
  c_irq_rise: cover property ($rose(irq));
  c_unmapped: cover property (pslverr);
  c_np_write: cover property (wr_acc && sel == SEL_NP);

endmodule : phy_autoneg_register_bank

// ==== hdl/phy_an_cfg.svh ====
// Behaviour
// [R1] identifier low word fixed, writes ignored
// [R2] advertise next page bit, writable, resets zero
// [R3] advertise remote fault bit, writable, resets zero
// [R4] pause field resets to symmetric pause
// [R5] four pair technology bit reads zero
// [R6] four duplex ability flags writable, reset one
// [R7] partner acknowledge reads one after word received
// [R8] partner remote fault from received base page
// [R9] parallel detection fault latched until read
// [R10] partner next page ability shown in expansion
// [R11] local next page able always reads one
// [R12] page received latched high on new page
// [R13] partner auto-negotiation able shown live
// [R14] next page follows bit, writable, resets zero
// [R15] message page bit, writable, resets one
// [R16] will comply bit, writable, resets zero
// [R17] toggle bit mirrors previous transmitted toggle
// [R18] latched bits hold until read, then follow
`ifndef PHY_AN_CFG_SVH
`define PHY_AN_CFG_SVH

// register indices; byte address is four times the index
`define IDX_ID_LOW      16'h0106
`define IDX_ADV         16'h0108
`define IDX_PARTNER     16'h010a
`define IDX_EXP         16'h010c
`define IDX_NP          16'h010e
`define IDX_IRQ_STAT    16'h0140
`define IDX_IRQ_MASK    16'h0141

// advertisement fields
`define ADV_NP_BIT      15
`define ADV_RF_BIT      13
`define ADV_PAUSE_HI    11
`define ADV_PAUSE_LO    10
`define ADV_T4_BIT      9
`define ADV_TECH_HI     8
`define ADV_TECH_LO     5
`define ADV_RST         16'h05e1
`define ADV_WMASK       16'hadff

// partner ability fields
`define LP_NP_BIT       15
`define LP_ACK_BIT      14
`define LP_RF_BIT       13

// expansion fields
`define EXP_PDF_BIT     4
`define EXP_LPNP_BIT    3
`define EXP_NPA_BIT     2
`define EXP_PR_BIT      1
`define EXP_LPAN_BIT    0

// next page fields
`define NP_MORE_BIT     15
`define NP_MSG_BIT      13
`define NP_ACK2_BIT     12
`define NP_TOG_BIT      11
`define NP_RST          16'h2001
`define NP_WMASK        16'hb7ff

// interrupt status layout
`define IRQ_PAGE_BIT    0
`define IRQ_FAULT_BIT   1
`define IRQ_BASE_BIT    2
`define IRQ_W           3

`endif

// ==== hdl/phy_an_pkg.sv ====
package phy_an_pkg;

  // events and levels from the arbitration logic
  typedef struct packed {
    logic        page_rx;          // one-cycle pulse, new page from partner
    logic        page_is_base;     // qualifies page_rx as base page
    logic        par_fault;        // one-cycle pulse, parallel detection fault
    logic        partner_an_able;  // level, partner can auto-negotiate
    logic        tx_toggle;        // level, toggle of previous sent word
    logic [15:0] page_word;        // received link code word
  } an_event_t;

  // one-hot register select
  typedef enum logic [7:0] {
    SEL_NONE     = 8'h01,
    SEL_ID_LOW   = 8'h02,
    SEL_ADV      = 8'h04,
    SEL_PARTNER  = 8'h08,
    SEL_EXP      = 8'h10,
    SEL_NP       = 8'h20,
    SEL_IRQ_STAT = 8'h40,
    SEL_IRQ_MASK = 8'h80
  } reg_sel_t;

endpackage : phy_an_pkg

// ==== hdl/sticky_bits.sv ====
`timescale 1ns/100ps
// bank of set-dominant sticky bits
module sticky_bits #(
  parameter int W = 2
) (
  input  wire logic         clk,    // core clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] set,    // set pulses
  input  wire logic [W-1:0] clr,    // clear pulses
  output logic      [W-1:0] q       // sticky values
);

  // set wins over a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else begin
          q[i] <= set[i] | (q[i] & ~clr[i]);
        end
      end
    end
  endgenerate

endmodule : sticky_bits

// ==== test/link_partner_model.sv ====
`timescale 1ns/100ps
// far-side link partner: delivers pages, faults and line levels to the bank
module link_partner_model
  import phy_an_pkg::*;
(
  input  wire logic clk,    // core clock
  output an_event_t an_evt  // events toward the bank
);
  // idle: no pulses, page word shows a non-matching pattern
  initial begin
    an_evt = '0;
    an_evt.page_word = 16'hc3c3;
  end

  // one-cycle page pulse; the word is not held once the pulse ends
  task automatic send_page(input logic [15:0] w, input logic base);
    @(posedge clk);
    an_evt.page_rx <= 1'b1;
    an_evt.page_is_base <= base;
    an_evt.page_word <= w;
    @(posedge clk);
    an_evt.page_rx <= 1'b0;
    an_evt.page_is_base <= 1'b0;
    an_evt.page_word <= ~w;
  endtask : send_page

  // one-cycle parallel detection fault
  task automatic send_fault();
    @(posedge clk);
    an_evt.par_fault <= 1'b1;
    @(posedge clk);
    an_evt.par_fault <= 1'b0;
  endtask : send_fault

  // partner ability and transmitted toggle levels
  task automatic levels(input logic able, input logic tog);
    @(posedge clk);
    an_evt.partner_an_able <= able;
    an_evt.tx_toggle <= tog;
  endtask : levels
endmodule : link_partner_model

// ==== test/phy_autoneg_register_bank_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module phy_autoneg_register_bank_tb;
  import phy_an_pkg::*;
  localparam logic [11:0] A_ID = 12'h418, A_ADV = 12'h420, A_LP = 12'h428;
  localparam logic [11:0] A_EXP = 12'h430, A_NP = 12'h438, A_IST = 12'h500;
  localparam logic [11:0] A_IMK = 12'h504, A_BAD = 12'h41c;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic er;} row_t;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] adv_word, np_word;
  an_event_t   an_evt;
  int          errors, n_compared;
  row_t        rows[20];

  phy_autoneg_register_bank #(.ADDR_W(12), .ID_LOW(16'h3c3c)) u_phy_autoneg_register_bank (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .an_evt(an_evt), .adv_word(adv_word), .np_word(np_word),
    .irq(irq));
  link_partner_model u_link_partner_model (.clk(clk), .an_evt(an_evt));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one apb transfer; read data and error land in rd and er
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let register updates of the access edge settle before callers look
    #1;
  endtask : apb

  // read and compare
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, '0);
    `CHK("read", e, rd)
  endtask : rdchk

  // counts and verdict
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    rows = '{
      '{A_ID, 0, 0, 32'h3c3c, 0}, '{A_ADV, 0, 0, 32'h05e1, 0}, '{A_LP, 0, 0, 0, 0},
      '{A_EXP, 0, 0, 32'h0004, 0}, '{A_NP, 0, 0, 32'h2001, 0}, '{A_IST, 0, 0, 0, 0},
      '{A_IMK, 0, 0, 0, 0}, '{A_BAD, 0, 0, 0, 1}, '{A_ID, 1, 32'hffff, 0, 0},
      '{A_ID, 0, 0, 32'h3c3c, 0}, '{A_ADV, 1, 32'hffff, 0, 0}, '{A_ADV, 0, 0, 32'hadff, 0},
      '{A_ADV, 1, 32'h0800, 0, 0}, '{A_ADV, 0, 0, 32'h0800, 0}, '{A_ADV, 1, 32'h0c00, 0, 0},
      '{A_ADV, 0, 0, 32'h0c00, 0}, '{A_NP, 1, 32'hffff, 0, 0}, '{A_NP, 0, 0, 32'hb7ff, 0},
      '{A_EXP, 1, 32'hffff, 0, 0}, '{A_LP, 1, 32'hffff, 0, 0}};
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // table of register accesses
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK("err", rows[i].er, er)
      if (!rows[i].w) `CHK("data", rows[i].e, rd)
    end
    rdchk(A_EXP, 32'h0004);
    rdchk(A_LP, 32'h0000);
    `CHK("adv_word", 16'h0c00, adv_word)
    // base page from the partner
    u_link_partner_model.levels(1'b1, 1'b1);
    u_link_partner_model.send_page(16'ha5e1, 1'b1);
    rdchk(A_LP, 32'he5e1);
    `CHK("irq", 1'b0, irq)
    rdchk(A_EXP, 32'h000f);
    rdchk(A_EXP, 32'h000d);
    rdchk(A_IST, 32'h5);
    apb(A_IMK, 1'b1, 32'h1);
    `CHK("irq", 1'b1, irq)
    apb(A_IST, 1'b1, 32'h1);
    `CHK("irq", 1'b0, irq)
    rdchk(A_NP, 32'hb7ff | 32'h0800);
    apb(A_NP, 1'b1, 32'h0);
    rdchk(A_NP, 32'h0800);
    `CHK("np_word", 16'h0800, np_word)
    // parallel fault latches until read
    u_link_partner_model.send_fault();
    repeat (6) @(posedge clk);
    rdchk(A_EXP, 32'h001d);
    rdchk(A_EXP, 32'h000d);
    rdchk(A_IST, 32'h6);
    apb(A_IMK, 1'b1, 32'h2);
    `CHK("irq", 1'b1, irq)
    // next page leaves partner word alone
    u_link_partner_model.send_page(16'h0000, 1'b0);
    rdchk(A_LP, 32'he5e1);
    rdchk(A_EXP, 32'h000f);
    u_link_partner_model.levels(1'b0, 1'b0);
    rdchk(A_EXP, 32'h000c);
    rdchk(A_NP, 32'h0000);
    // reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(A_ADV, 32'h05e1);
    `CHK("adv_word", 16'h05e1, adv_word)
    rdchk(A_LP, 32'h0000);
    `CHK("irq", 1'b0, irq)
    summarize();
  end
endmodule : phy_autoneg_register_bank_tb
